// ==== rtl/osc_pkg.sv ====
// Summary of operation
// - Every control and diagnosis exchange on the serial port is a frame of sixteen bits per device.
// - The serial shift path delays bits by one sixteen-bit frame, so only devices with sixteen-bit frames may share the chain.
// - With the sleep-control pin low, the two direct inputs still switch channels 2 and 3 without the digital supply.
// - Each direct input has a channel map, so one input can drive another channel or several channels at once.
// - The off-state open-load test current on a channel flows only when the serial port has commanded it.
// - A channel that reaches its overcurrent threshold turns off and stays off until a serial clear command or a fail-safe restart.
// - In fail-safe mode a shut-off channel whose input is high restarts by itself after the restart time.
// - On-state open-load diagnosis runs only on channels whose load is wired high-side.
// - Every channel has its own temperature input, which switches that channel off when it is too hot.
// - After reset the first direct input drives channel 2 and the second drives channel 3.
// - A channel's drive is the OR of its serial enable, the mapped pulse generators and the mapped inputs.
package osc_pkg;

  localparam int OSC_CH = 8;
  localparam int OSC_FRAME_BITS = 16;
  localparam int OSC_CNT_W = 5;

  // Serial register addresses.
  localparam logic [2:0] OSC_ADDR_EN = 3'h0;
  localparam logic [2:0] OSC_ADDR_IN_ZERO_MAP = 3'h1;
  localparam logic [2:0] OSC_ADDR_IN_ONE_MAP = 3'h2;
  localparam logic [2:0] OSC_ADDR_PMAP0 = 3'h3;
  localparam logic [2:0] OSC_ADDR_PMAP1 = 3'h4;
  localparam logic [2:0] OSC_ADDR_OLOFF = 3'h5;
  localparam logic [2:0] OSC_ADDR_OLON = 3'h6;
  localparam logic [2:0] OSC_ADDR_CLEAR = 3'h7;

  // Reset values.
  localparam logic [7:0] OSC_RST_EN = 8'h00;
  localparam logic [7:0] OSC_RST_IN_ZERO_MAP = 8'h04;
  localparam logic [7:0] OSC_RST_IN_ONE_MAP = 8'h08;
  localparam logic [7:0] OSC_RST_PMAP = 8'h00;
  localparam logic [7:0] OSC_RST_OL = 8'h00;

  // Timing.
  localparam int OSC_CLK_HZ = 50_000_000;
  localparam int OSC_TICK_TIME_MS = 1;
  localparam int OSC_TICK_CYCLES = OSC_CLK_HZ / 1000 * OSC_TICK_TIME_MS;
  localparam int OSC_RETRY_TIME_MS = 10;
  localparam int OSC_RETRY_TICKS = OSC_RETRY_TIME_MS / OSC_TICK_TIME_MS;

  // Synchroniser bit positions.
  localparam int OSC_S_SDI = 0;
  localparam int OSC_S_CSN = 1;
  localparam int OSC_S_SCLK = 2;
  localparam int OSC_S_IN_ZERO = 3;
  localparam int OSC_S_IN_ONE = 4;
  localparam int OSC_S_SLP = 5;
  localparam int OSC_S_VDD = 6;
  localparam int OSC_S_OC = 7;
  localparam int OSC_S_OT = OSC_S_OC + OSC_CH;
  localparam int OSC_S_W = OSC_S_OT + OSC_CH;

  typedef struct packed {
    logic wr;
    logic [2:0] addr;
    logic [3:0] rsvd;
    logic [7:0] data;
  } osc_frame_s;

  typedef struct packed {
    logic [7:0] fault;
    logic [7:0] data;
  } osc_reply_s;

endpackage

// ==== rtl/osc_channel.sv ====
`timescale 1ns/1ps
module osc_channel
  import osc_pkg::*;
#(
  parameter int RETRY_TICKS = OSC_RETRY_TICKS
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic drive_i,
  input wire logic limp_i,
  input wire logic clear_i,
  input wire logic tick_i,
  // Protection sensors
  input wire logic overcurrent_i,
  input wire logic overtemp_i,
  // Status
  output logic on_o,
  output logic fault_o
);

  localparam int RW = $clog2(RETRY_TICKS + 1);
  localparam logic [RW-1:0] RETRY_END = RW'(RETRY_TICKS);

  logic latch_q, latch_d;
  logic on_q, on_d;
  logic [RW-1:0] cnt_q, cnt_d;
  logic trip;
  logic waiting;
  logic restart;

  assign trip = on_q & (overcurrent_i | overtemp_i);
  assign waiting = limp_i & drive_i & latch_q;
  assign restart = waiting & (cnt_q == RETRY_END);
  assign cnt_d = !waiting ? '0 :
                 (tick_i && cnt_q != RETRY_END) ? cnt_q + RW'(1) : cnt_q;
  assign latch_d = trip | (latch_q & ~clear_i & ~restart);
  assign on_d = drive_i & ~latch_d & ~overtemp_i & ~overcurrent_i;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      latch_q <= 1'b0;
      on_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      latch_q <= latch_d;
      on_q <= on_d;
      cnt_q <= cnt_d;
    end
  end

  assign on_o = on_q;
  assign fault_o = latch_q;

endmodule

// ==== rtl/osc_switch_ctrl.sv ====
`timescale 1ns/1ps
module osc_switch_ctrl
  import osc_pkg::*;
#(
  parameter int TICK_CYCLES = OSC_TICK_CYCLES,
  parameter int RETRY_TICKS = OSC_RETRY_TICKS
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Serial port pins
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  // Direct control pins
  input wire logic direct_input_zero_i,
  input wire logic direct_input_one_i,
  input wire logic sleep_control_pin_n_i,
  input wire logic vdd_ok_i,
  // Internal pulse generators, same clock
  input wire logic [1:0] pwm_gen_i,
  // Analog sensing
  input wire logic [OSC_CH-1:0] overcurrent_i,
  input wire logic [OSC_CH-1:0] overtemp_i,
  input wire logic [OSC_CH-1:0] high_side_i,
  // Power stage controls
  output logic [OSC_CH-1:0] channel_on_o,
  output logic [OSC_CH-1:0] open_load_test_current_o,
  output logic [OSC_CH-1:0] open_load_on_diag_o,
  output logic limp_home_o
);

  // ******************************************************************
  // Input synchronisers
  // ******************************************************************
  logic [OSC_S_W-1:0] async_w;
  logic [OSC_S_W-1:0] meta_q;
  logic [OSC_S_W-1:0] sync_q;

  assign async_w = {overtemp_i, overcurrent_i, vdd_ok_i,
                    sleep_control_pin_n_i, direct_input_one_i,
                    direct_input_zero_i, spi_sclk_i, spi_cs_n_i, spi_sdi_i};

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_w;
      sync_q <= meta_q;
    end
  end

  logic sdi_s, csn_s, sclk_s, awake_s, vdd_s;
  logic direct_input_zero_s, direct_input_one_s;
  logic [OSC_CH-1:0] oc_s, ot_s;
  assign sdi_s = sync_q[OSC_S_SDI];
  assign csn_s = sync_q[OSC_S_CSN];
  assign sclk_s = sync_q[OSC_S_SCLK];
  assign direct_input_zero_s = sync_q[OSC_S_IN_ZERO];
  assign direct_input_one_s = sync_q[OSC_S_IN_ONE];
  assign awake_s = sync_q[OSC_S_SLP];
  assign vdd_s = sync_q[OSC_S_VDD];
  assign oc_s = sync_q[OSC_S_OC +: OSC_CH];
  assign ot_s = sync_q[OSC_S_OT +: OSC_CH];

  // Registers lose their contents whenever the serial side is unpowered.
  logic spi_ok;
  logic limp;
  assign spi_ok = vdd_s & awake_s;
  assign limp = ~awake_s & (direct_input_zero_s | direct_input_one_s);

  // ******************************************************************
  // Serial shift engine
  // ******************************************************************
  logic sclk_q, csn_q;
  logic [OSC_FRAME_BITS-1:0] shift_q, shift_d;
  logic [OSC_CNT_W-1:0] bits_q, bits_d;
  logic sdo_q, sdo_d;
  logic sdo_oe_q;
  logic cs_fall, cs_rise, sclk_rise, sclk_fall;
  logic frame_ok;
  osc_frame_s frame;
  osc_reply_s reply;

  assign cs_fall = csn_q & ~csn_s & spi_ok;
  assign cs_rise = ~csn_q & csn_s;
  assign sclk_rise = ~csn_s & ~sclk_q & sclk_s & spi_ok;
  assign sclk_fall = ~csn_s & sclk_q & ~sclk_s & spi_ok;
  assign frame = osc_frame_s'(shift_q);
  assign frame_ok = spi_ok & cs_rise & (bits_q[3:0] == 4'h0) &
                    (bits_q != '0);

  assign shift_d = cs_fall ? OSC_FRAME_BITS'(reply) :
                   sclk_fall ? {shift_q[OSC_FRAME_BITS-2:0], sdi_s} :
                   shift_q;
  // Counter wraps on multiples of sixteen, so long chains still commit.
  assign bits_d = cs_fall ? '0 :
                  sclk_fall ? {1'b1, bits_q[3:0] + 4'h1} : bits_q;
  assign sdo_d = cs_fall ? reply.fault[7] :
                 sclk_rise ? shift_q[OSC_FRAME_BITS-1] : sdo_q;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sclk_q <= 1'b0;
      csn_q <= 1'b1;
      shift_q <= '0;
      bits_q <= '0;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
      csn_q <= csn_s;
      shift_q <= shift_d;
      bits_q <= bits_d;
      sdo_q <= sdo_d;
      sdo_oe_q <= ~csn_s & spi_ok;
    end
  end

  // ******************************************************************
  // Register file
  // ******************************************************************
  logic [7:0] en_q, pmap0_q, pmap1_q, oloff_q, olon_q;
  logic [7:0] input_zero_channel_map_q, input_one_channel_map_q;
  logic [2:0] rd_addr_q;
  logic [7:0] rd_data;
  logic [OSC_CH-1:0] clear_q;
  logic [OSC_CH-1:0] fault_w;
  logic wr;

  assign wr = frame_ok & frame.wr;
  assign rd_data = (rd_addr_q == OSC_ADDR_EN) ? en_q :
                   (rd_addr_q == OSC_ADDR_IN_ZERO_MAP) ?
                   input_zero_channel_map_q :
                   (rd_addr_q == OSC_ADDR_IN_ONE_MAP) ?
                   input_one_channel_map_q :
                   (rd_addr_q == OSC_ADDR_PMAP0) ? pmap0_q :
                   (rd_addr_q == OSC_ADDR_PMAP1) ? pmap1_q :
                   (rd_addr_q == OSC_ADDR_OLOFF) ? oloff_q :
                   (rd_addr_q == OSC_ADDR_OLON) ? olon_q :
                   channel_on_o;
  assign reply = '{fault: fault_w, data: rd_data};

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || !spi_ok) begin
      en_q <= OSC_RST_EN;
      input_zero_channel_map_q <= OSC_RST_IN_ZERO_MAP;
      input_one_channel_map_q <= OSC_RST_IN_ONE_MAP;
      pmap0_q <= OSC_RST_PMAP;
      pmap1_q <= OSC_RST_PMAP;
      oloff_q <= OSC_RST_OL;
      olon_q <= OSC_RST_OL;
      rd_addr_q <= OSC_ADDR_EN;
      clear_q <= '0;
    end else begin
      if (frame_ok) begin
        rd_addr_q <= frame.addr;
      end
      if (wr && frame.addr == OSC_ADDR_EN) begin
        en_q <= frame.data;
      end
      if (wr && frame.addr == OSC_ADDR_IN_ZERO_MAP) begin
        input_zero_channel_map_q <= frame.data;
      end
      if (wr && frame.addr == OSC_ADDR_IN_ONE_MAP) begin
        input_one_channel_map_q <= frame.data;
      end
      if (wr && frame.addr == OSC_ADDR_PMAP0) begin
        pmap0_q <= frame.data;
      end
      if (wr && frame.addr == OSC_ADDR_PMAP1) begin
        pmap1_q <= frame.data;
      end
      if (wr && frame.addr == OSC_ADDR_OLOFF) begin
        oloff_q <= frame.data;
      end
      if (wr && frame.addr == OSC_ADDR_OLON) begin
        olon_q <= frame.data;
      end
      clear_q <= (wr && frame.addr == OSC_ADDR_CLEAR) ? frame.data : '0;
    end
  end

  // ******************************************************************
  // Millisecond tick
  // ******************************************************************
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_END = TW'(TICK_CYCLES - 1);
  logic [TW-1:0] div_q;
  logic tick_q;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= (div_q == TICK_END) ? '0 : div_q + TW'(1);
      tick_q <= (div_q == TICK_END);
    end
  end

  // ******************************************************************
  // Channel drive and protection
  // ******************************************************************
  logic [OSC_CH-1:0] drive_w;
  logic [OSC_CH-1:0] on_w;
  logic [OSC_CH-1:0] oltc_q, olon_diag_q;
  logic limp_q;

  assign drive_w = en_q | (pmap0_q & {OSC_CH{pwm_gen_i[0]}}) |
                   (pmap1_q & {OSC_CH{pwm_gen_i[1]}}) |
                   (input_zero_channel_map_q &
                    {OSC_CH{direct_input_zero_s}}) |
                   (input_one_channel_map_q &
                    {OSC_CH{direct_input_one_s}});

  genvar g;
  generate
    for (g = 0; g < OSC_CH; g++) begin : g_ch
      osc_channel #(
        .RETRY_TICKS(RETRY_TICKS)
      ) u_ch (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .drive_i(drive_w[g]),
        .limp_i(limp),
        .clear_i(clear_q[g]),
        .tick_i(tick_q),
        .overcurrent_i(oc_s[g]),
        .overtemp_i(ot_s[g]),
        .on_o(on_w[g]),
        .fault_o(fault_w[g])
      );
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      oltc_q <= '0;
      olon_diag_q <= '0;
      limp_q <= 1'b0;
    end else begin
      oltc_q <= oloff_q & ~on_w;
      olon_diag_q <= olon_q & high_side_i & on_w;
      limp_q <= limp;
    end
  end

  assign channel_on_o = on_w;
  assign open_load_test_current_o = oltc_q;
  assign open_load_on_diag_o = olon_diag_q;
  assign limp_home_o = limp_q;
  assign spi_sdo_o = sdo_q;
  assign spi_sdo_oe_o = sdo_oe_q;

endmodule

// ==== test/osc_switch_ctrl_assertions.sv ====
`timescale 1ns/1ps
module osc_switch_ctrl_assertions
  import osc_pkg::*;
(
  // Clock, reset and pins
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic spi_cs_n_i,
  input wire logic direct_input_zero_i,
  input wire logic sleep_control_pin_n_i,
  input wire logic vdd_ok_i,
  input wire logic [OSC_CH-1:0] overcurrent_i,
  input wire logic [OSC_CH-1:0] overtemp_i,
  input wire logic [OSC_CH-1:0] high_side_i,
  // Outputs watched
  input wire logic spi_sdo_oe_o,
  input wire logic [OSC_CH-1:0] channel_on_o,
  input wire logic [OSC_CH-1:0] open_load_test_current_o,
  input wire logic [OSC_CH-1:0] open_load_on_diag_o,
  input wire logic limp_home_o
);
  // ****************************************
  // Checks at the ports
  // ****************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  wire logic awake = sleep_control_pin_n_i && vdd_ok_i;
  wire logic [OSC_CH-1:0] hot = overcurrent_i | overtemp_i;
  sequence s_limp;
    (!sleep_control_pin_n_i && direct_input_zero_i)[*5];
  endsequence
  sequence s_lh0;
    (!sleep_control_pin_n_i && direct_input_zero_i && !hot[2])[*6];
  endsequence
  // Four samples cover the sync lag and the output register.
  AST_HOT_OFF: assert property (
    (hot & $past(hot) & $past(hot, 2) & $past(hot, 3) & channel_on_o) == 0)
    else $error("channel on while sensor high");
  AST_TEST_OFF: assert property (
    (open_load_test_current_o & $past(channel_on_o)) == 0)
    else $error("test current on a driven channel");
  AST_DIAG_HS: assert property (
    (open_load_on_diag_o & ~($past(high_side_i) & $past(channel_on_o))) == 0)
    else $error("on diag without high side load");
  AST_LIMP_ON: assert property (s_limp |-> limp_home_o)
    else $error("fail-safe mode not entered");
  AST_LIMP_OFF: assert property (
    sleep_control_pin_n_i [*5] |-> !limp_home_o)
    else $error("fail-safe mode while awake");
  AST_OE_ON: assert property (
    (!spi_cs_n_i && awake)[*4] |-> spi_sdo_oe_o)
    else $error("serial out not driven");
  AST_OE_OFF: assert property (
    (spi_cs_n_i || !awake)[*4] |-> !spi_sdo_oe_o)
    else $error("serial out driven when idle");
  AST_LIMP_CH2: assert property (
    $fell(sleep_control_pin_n_i) ##1 s_lh0 |-> channel_on_o[2])
    else $error("first input does not drive channel 2");
endmodule
bind osc_switch_ctrl osc_switch_ctrl_assertions u_chk (.sys_clk_i,
  .sys_rst_i, .spi_cs_n_i, .direct_input_zero_i, .sleep_control_pin_n_i,
  .vdd_ok_i, .overcurrent_i, .overtemp_i, .high_side_i, .spi_sdo_oe_o,
  .channel_on_o, .open_load_test_current_o, .open_load_on_diag_o,
  .limp_home_o);

// ==== test/osc_spi_host.sv ====
`timescale 1ns/1ps
module osc_spi_host (
  // Clock
  input wire logic clk_i,
  // Serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  // ****************************************
  // Host side of the serial port
  // ****************************************
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  task automatic step();
    repeat (5) @(posedge clk_i);
  endtask
  // two 16-bit units
  // Serial clock idles low between frames; data in flips once released.
  // Data out changes after each rise, so it is taken just before the fall.
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    cs_n_o <= 1'b0;
    step();
    for (int i = 31; i >= 0; i--) begin
      sdi_o <= tx[i];
      sclk_o <= 1'b1;
      step();
      rx[i] = sdo_i;
      sclk_o <= 1'b0;
      step();
    end
    cs_n_o <= 1'b1;
    sdi_o <= ~tx[0];
    step();
  endtask
endmodule

// ==== test/tb_osc_switch_ctrl.sv ====
`timescale 1ns/1ps
module tb_osc_switch_ctrl
  import osc_pkg::*;
;
  logic sys_clk_i, sys_rst_i, sclk, cs_n, sdi, sdo, sdo_oe;
  logic in_zero, in_one, slp_n, vdd_ok, lh;
  logic [1:0] pwm;
  logic [OSC_CH-1:0] oc, ot, hs, on, olt, old;
  logic [31:0] rx;
  logic [15:0] d16;
  logic [7:0] en, m0;
  int bad_count, cmp_count;
  // Released serial output reads back inverted, never a stale level.
  wire logic sdo_w = sdo_oe ? sdo : ~sdo;
  osc_switch_ctrl #(.TICK_CYCLES(10), .RETRY_TICKS(3)) DUT (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .spi_sclk_i(sclk),
    .spi_cs_n_i(cs_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo),
    .spi_sdo_oe_o(sdo_oe), .direct_input_zero_i(in_zero),
    .direct_input_one_i(in_one), .sleep_control_pin_n_i(slp_n),
    .vdd_ok_i(vdd_ok), .pwm_gen_i(pwm), .overcurrent_i(oc),
    .overtemp_i(ot), .high_side_i(hs), .channel_on_o(on),
    .open_load_test_current_o(olt), .open_load_on_diag_o(old),
    .limp_home_o(lh));
  osc_spi_host host (.clk_i(sys_clk_i), .sclk_o(sclk), .cs_n_o(cs_n),
    .sdi_o(sdi), .sdo_i(sdo_w));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] f_on(input logic [7:0] e, a,
                                      input logic i, j);
    return e | (i ? a : 8'h00) | (j ? 8'h08 : 8'h00);
  endfunction
  task automatic cmp(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic xf(input logic w, input logic [2:0] a,
                    input logic [7:0] d);
    logic [7:0] p;
    p = 8'($urandom);
    host.xfer({p, 8'h00, w, a, 4'h0, d}, rx);
    cmp(rx[15:8], p);
  endtask
  task automatic rd(input logic [2:0] a);
    xf(1'b0, a, 8'h00);
    xf(1'b0, OSC_ADDR_EN, 8'h00);
    d16 = rx[31:16];
  endtask
  task automatic settle(input logic [7:0] exp);
    int n;
    n = 0;
    while (on !== exp && n < 200) begin
      @(posedge sys_clk_i);
      n++;
    end
    cmp(on, exp);
    if (on !== exp)
      end_of_test();
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {sys_rst_i, slp_n, vdd_ok} = 3'b111;
    {in_zero, in_one, pwm, oc, ot, hs} = '0;
    bad_count = 0;
    cmp_count = 0;
    en = 8'($urandom(32'h777ec012));
    repeat (8) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    cmp(on, 8'h00);
    rd(OSC_ADDR_IN_ZERO_MAP);
    cmp(d16[7:0], 8'h04);
    rd(OSC_ADDR_IN_ONE_MAP);
    cmp(d16[7:0], 8'h08);
    for (int k = 0; k < 4; k++) begin
      en = 8'($urandom);
      m0 = 8'($urandom);
      xf(1'b1, OSC_ADDR_EN, en);
      xf(1'b1, OSC_ADDR_IN_ZERO_MAP, m0);
      in_zero <= k[0];
      in_one <= k[1];
      settle(f_on(en, m0, k[0], k[1]));
    end
    {in_zero, in_one} <= 2'b00;
    xf(1'b1, OSC_ADDR_EN, 8'h00);
    xf(1'b1, OSC_ADDR_PMAP1, 8'h81);
    pwm <= 2'b10;
    settle(8'h81);
    pwm <= 2'b00;
    xf(1'b1, OSC_ADDR_EN, 8'h0f);
    settle(8'h0f);
    cmp(olt, 8'h00);
    hs <= 8'h55;
    xf(1'b1, OSC_ADDR_OLOFF, 8'hff);
    xf(1'b1, OSC_ADDR_OLON, 8'hff);
    cmp(olt, 8'hf0);
    cmp(old, 8'h05);
    xf(1'b1, OSC_ADDR_EN, 8'hff);
    settle(8'hff);
    oc <= 8'h02;
    ot <= 8'h20;
    repeat (6) @(posedge sys_clk_i);
    {oc, ot} <= '0;
    repeat (20) @(posedge sys_clk_i);
    cmp(on, 8'hdd);
    rd(OSC_ADDR_EN);
    cmp(d16[15:8], 8'h22);
    xf(1'b1, OSC_ADDR_CLEAR, 8'h22);
    settle(8'hff);
    {vdd_ok, slp_n, in_zero} <= 3'b001;
    settle(8'h04);
    cmp({7'h00, lh}, 8'h01);
    oc <= 8'h04;
    repeat (6) @(posedge sys_clk_i);
    oc <= 8'h00;
    repeat (10) @(posedge sys_clk_i);
    cmp(on, 8'h00);
    settle(8'h04);
    end_of_test();
  end
endmodule
